//--- dv/phy_strap_config_loader_bench.sv
`include "pscl_params.svh"
`default_nettype none
module phy_strap_config_loader_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import pscl_pkg::*;
  logic clk = 1'b0, reset = 1'b1, pinResetLow = 1'b1, strapActive = 1'b1;
  logic regWrite = 1'b0, regRead = 1'b0;
  logic rxErrPin, rxClkPin, colPin, rmiiPin, irqPin, frameMatch;
  logic [3:0] rxDataPin;
  logic [4:0] frameAddress = 5'h00, regAddr = 5'h00, scramblerSeed;
  logic [15:0] regWriteData = 16'h0000, regReadData, bc;
  logic [31:0] r;
  pscl_straps_type straps = '0;
  pscl_core_cfg_type coreCfg;
  int errCount = 0, nCompared = 0, cycles = 0, seed, code;
  logic [15:0] bcTable [8] = '{16'h0000, 16'h0100, 16'h2000, 16'h2100,
                               16'h3000, 16'h3000, 16'h0000, 16'h3100};
  logic [15:0] advTable [8] = '{16'h01E1, 16'h01E1, 16'h01E1, 16'h01E1,
                                16'h0081, 16'h0081, 16'h01E1, 16'h01E1};
  pscl_strap_board u_board (.clk(clk), .strapActive(strapActive), .straps(straps),
    .rxErrPin(rxErrPin), .rxClkPin(rxClkPin), .rxDataPin(rxDataPin), .colPin(colPin),
    .rmiiPin(rmiiPin), .irqPin(irqPin));
  pscl_loader u_dut (.clk(clk), .reset(reset), .pinResetLow(pinResetLow),
    .rxErrPin(rxErrPin), .rxClkPin(rxClkPin), .rxDataPin(rxDataPin), .colPin(colPin),
    .reducedIfSelectStrap(rmiiPin), .irqPinFunctionStrap(irqPin),
    .frameAddress(frameAddress), .frameMatch(frameMatch), .regAddr(regAddr),
    .regWriteData(regWriteData), .regWrite(regWrite), .regRead(regRead),
    .regReadData(regReadData), .coreCfg(coreCfg), .scramblerSeed(scramblerSeed));
  initial forever #2 clk = ~clk;
  task automatic printVerdict();
    $display("compared %0d mismatches %0d", nCompared, errCount);
    if (errCount == 0 && nCompared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : printVerdict
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      errCount++;
      printVerdict();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    nCompared++;
    if (got !== exp) begin
      errCount++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wrReg(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWriteData <= d;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask : wrReg
  task automatic rdChk(input logic [4:0] a, input logic [15:0] exp);
    @(posedge clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRead <= 1'b0;
    #1;
    chk(regReadData, exp);
  endtask : rdChk
  // straps held past the release edge, then the pins carry traffic
  task automatic pinReset(input logic [2:0] m, input logic [31:0] v);
    @(posedge clk);
    straps <= '{v[2:0], m, v[3], v[4]};
    strapActive <= 1'b1;
    pinResetLow <= 1'b0;
    repeat (4) @(posedge clk);
    pinResetLow <= 1'b1;
    repeat (2) @(posedge clk);
    strapActive <= 1'b0;
    repeat (6) @(posedge clk);
  endtask : pinReset
  task automatic frameChk(input logic [4:0] a);
    chk({11'h000, scramblerSeed}, {11'h000, a});
    @(posedge clk);
    frameAddress <= a;
    @(posedge clk);
    frameAddress <= a ^ 5'h01;
    #1;
    chk({15'h0000, frameMatch}, 16'h0001);
    @(posedge clk);
    #1;
    chk({15'h0000, frameMatch}, 16'h0000);
  endtask : frameChk
  initial begin
    seed = 32'hAA11;
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    for (code = 0; code < 8; code++) begin
      r = $random(seed);
      pinReset(code[2:0], r);
      bc = bcTable[code];
      if (code != 6) begin
        rdChk(`PSCL_ADDR_BCTRL, bc);
        chk({8'h00, coreCfg}, {8'h00, bc[13], bc[12], bc[8], 1'h0,
            !bc[8] && code != 5, code == 5, r[3], r[4]});
      end
      chk({15'h0000, coreCfg.powerDown}, {15'h0000, code == 6});
      rdChk(`PSCL_ADDR_ADVERT, advTable[code]);
      rdChk(`PSCL_ADDR_SPMODES, {1'h0, r[3], 6'h00, code[2:0], 2'h0, r[2:0]});
      rdChk(`PSCL_ADDR_STRAPS, {8'h00, r[2:0], code[2:0], r[3], r[4]});
      frameChk({2'h0, r[2:0]});
      $display("test strap code %0d done", code);
    end
    wrReg(`PSCL_ADDR_SPMODES, 16'h00F5);
    repeat (2) @(posedge clk);
    frameChk(5'h15);
    rdChk(5'h1F, 16'h0000);
    $display("test address write done");
    r = $random(seed);
    pinReset(3'h6, r);
    chk({15'h0000, coreCfg.powerDown}, 16'h0001);
    wrReg(`PSCL_ADDR_SPMODES, {8'h00, 3'h3, 2'h0, r[2:0]});
    wrReg(`PSCL_ADDR_BCTRL, 16'hA100);
    repeat (24) @(posedge clk);
    rdChk(`PSCL_ADDR_BCTRL, 16'h2100);
    chk({12'h000, coreCfg[7:4]}, 16'h000A);
    repeat (70) @(posedge clk);
    $display("test soft reset done");
    printVerdict();
  end
endmodule : phy_strap_config_loader_bench
`default_nettype wire

//--- dv/pscl_loader_assertions.sv
`include "pscl_params.svh"
`default_nettype none
module pscl_loader_assertions (
  // clock and resets
  input wire logic                        clk,
  input wire logic                        reset,
  input wire logic                        pinResetLow,
  // watched ports
  input wire logic [4:0]                  frameAddress,
  input wire logic                        frameMatch,
  input wire logic [4:0]                  regAddr,
  input wire logic                        regWrite,
  input wire logic                        regRead,
  input wire logic [15:0]                 regReadData,
  input wire pscl_pkg::pscl_core_cfg_type coreCfg,
  input wire logic [4:0]                  scramblerSeed
);
  import pscl_pkg::*;
  logic [5:0] quietCnt;
  // slack must outlast the soft reset before outputs count as settled
  always_ff @(posedge clk) begin
    if (reset || !pinResetLow || regWrite) begin
      quietCnt <= 6'h00;
    end else if (quietCnt != 6'h3F) begin
      quietCnt <= quietCnt + 6'h01;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  a_idle_read_zero: assert property (!regRead |=> regReadData == 16'h0000)
    else $error("read data outside answer cycle");
  a_frame_match: assert property (
    !$past(reset) |-> frameMatch == ($past(frameAddress) == scramblerSeed))
    else $error("frame match disagrees with own address");
  a_spmodes_addr: assert property (
    regRead && regAddr == `PSCL_ADDR_SPMODES |=> regReadData[4:0] == scramblerSeed)
    else $error("address field differs from scrambler seed");
  a_bctrl_core: assert property (
    regRead && regAddr == `PSCL_ADDR_BCTRL && quietCnt > 6'h14 |=>
    {coreCfg.speed100, coreCfg.autoNegEnable, coreCfg.fullDuplex} ==
    {regReadData[13], regReadData[12], regReadData[8]})
    else $error("core config differs from control register");
  a_cfg_held: assert property (
    quietCnt == 6'h3F |-> $stable(coreCfg) && $stable(scramblerSeed))
    else $error("config moved without reset or write");
  a_crs_rx_only: assert property (
    coreCfg.fullDuplex || coreCfg.repeaterMode |-> !coreCfg.crsOnTransmit)
    else $error("carrier sense on transmit when not allowed");
  a_crs_tx_rx: assert property (
    coreCfg.speed100 && !coreCfg.fullDuplex && !coreCfg.repeaterMode |->
    coreCfg.crsOnTransmit)
    else $error("carrier sense on transmit missing");
  a_repeater_an: assert property (
    coreCfg.repeaterMode |-> coreCfg.autoNegEnable && coreCfg.speed100)
    else $error("repeater without autoneg at 100");
endmodule : pscl_loader_assertions
bind pscl_loader pscl_loader_assertions u_chk (
  .clk(clk), .reset(reset), .pinResetLow(pinResetLow),
  .frameAddress(frameAddress), .frameMatch(frameMatch), .regAddr(regAddr),
  .regWrite(regWrite), .regRead(regRead), .regReadData(regReadData),
  .coreCfg(coreCfg), .scramblerSeed(scramblerSeed)
);
`default_nettype wire

//--- dv/pscl_strap_board.sv
`default_nettype none
module pscl_strap_board (
  // strap settings
  input  wire logic                      clk,
  input  wire logic                      strapActive,
  input  wire pscl_pkg::pscl_straps_type straps,
  // shared pins
  output logic                           rxErrPin,
  output logic                           rxClkPin,
  output logic [3:0]                     rxDataPin,
  output logic                           colPin,
  output logic                           rmiiPin,
  output logic                           irqPin
);
  import pscl_pkg::*;
  logic       flip = 1'b0;
  logic [5:0] shared;
  always @(posedge clk) flip <= ~flip;
  // receive traffic takes the shared pins once sampling ends
  assign shared = {straps.mgmtAddressStrap, straps.modeStrap} ^ {6{flip & ~strapActive}};
  assign rxErrPin = shared[3];
  assign rxClkPin = shared[4];
  assign rxDataPin = {shared[5], flip, shared[1:0]};
  assign colPin = shared[2];
  assign rmiiPin = straps.reducedIfSelectStrap;
  assign irqPin = straps.irqPinFunctionStrap;
endmodule : pscl_strap_board
`default_nettype wire

//--- hdl/pscl_loader.sv
`include "pscl_params.svh"
`default_nettype none
module pscl_loader (
  // clock and reset
  input  wire logic                       clk,
  input  wire logic                       reset,
  input  wire logic                       pinResetLow,
  // shared receive pins sampled as straps
  input  wire logic                       rxErrPin,
  input  wire logic                       rxClkPin,
  input  wire logic [3:0]                 rxDataPin,
  input  wire logic                       colPin,
  input  wire logic                       reducedIfSelectStrap,
  input  wire logic                       irqPinFunctionStrap,
  // management frame address compare
  input  wire logic [4:0]                 frameAddress,
  output logic                            frameMatch,
  // register port
  input  wire logic [4:0]                 regAddr,
  input  wire logic [15:0]                regWriteData,
  input  wire logic                       regWrite,
  input  wire logic                       regRead,
  output logic [15:0]                     regReadData,
  // core configuration
  output pscl_pkg::pscl_core_cfg_type     coreCfg,
  output logic [4:0]                      scramblerSeed
);
  import pscl_pkg::*;

  pscl_state_type    state_reg, state_next;
  pscl_straps_type   straps_reg;
  pscl_straps_type   pinStraps;
  logic [15:0]       bctrl_reg, bctrl_next;
  logic [15:0]       advert_reg, advert_next;
  logic [4:0]        addr_reg, addr_next;
  logic [2:0]        mode_reg, mode_next;
  logic              ifKind_reg, ifKind_next;
  logic              pinLowSeen_reg;
  logic [7:0]        swCnt_reg, swCnt_next;
  logic [15:0]       readMux;
  logic              frameMatch_reg;
  logic [4:0]        seed_reg;
  pscl_core_cfg_type coreCfg_reg, coreCfg_next;

  // strap pin mapping
  assign pinStraps.mgmtAddressStrap     = {rxDataPin[3], rxClkPin, rxErrPin};
  assign pinStraps.modeStrap            = {colPin, rxDataPin[1:0]};
  assign pinStraps.reducedIfSelectStrap = reducedIfSelectStrap;
  assign pinStraps.irqPinFunctionStrap  = irqPinFunctionStrap;

  wire pinResetRelease = pinLowSeen_reg & pinResetLow;
  wire hwReload        = reset | pinResetRelease;
  wire inHwReset       = reset | ~pinResetLow;
  wire swResetReq      = regWrite & (regAddr == `PSCL_ADDR_BCTRL)
                         & regWriteData[`PSCL_BC_SOFTRST];
  wire swDone          = (state_reg == PSCL_SWRST) & (swCnt_reg == 8'h00);

  // strap decode of the mode code
  logic [3:0] modeCtl;
  logic [3:0] modeAdv;
  logic       modeHasAdv;
  always_comb begin
    modeCtl    = 4'h0;
    modeAdv    = 4'h0;
    modeHasAdv = 1'b0;
    case (straps_reg.modeStrap)
      3'h0: modeCtl = 4'h0;
      3'h1: modeCtl = 4'h1;
      3'h2: modeCtl = 4'h8;
      3'h3: modeCtl = 4'h9;
      3'h4, 3'h5: begin
        modeCtl    = 4'hC;
        modeAdv    = 4'h4;
        modeHasAdv = 1'b1;
      end
      // X bits resolved to 1 so all-capable starts at 100 full
      3'h7: begin
        modeCtl    = 4'hD;
        modeAdv    = 4'hF;
        modeHasAdv = 1'b1;
      end
      default: modeCtl = 4'h0;
    endcase
  end

  // basic control default built from the mode code
  logic [15:0] bctrlFromStrap;
  always_comb begin
    bctrlFromStrap                  = 16'h0000;
    bctrlFromStrap[`PSCL_BC_SPEED]  = modeCtl[3];
    bctrlFromStrap[`PSCL_BC_ANEN]   = modeCtl[2];
    bctrlFromStrap[10]              = modeCtl[1];
    bctrlFromStrap[`PSCL_BC_DUPLEX] = modeCtl[0];
    bctrlFromStrap[`PSCL_BC_PDOWN]  = (straps_reg.modeStrap == 3'h6);
  end

  wire [15:0] advertFromStrap = modeHasAdv ?
    ((`PSCL_ADVERT_RST & ~`PSCL_ADVERT_MASK) | {7'h00, modeAdv, 5'h00})
    : `PSCL_ADVERT_RST;

  // soft reset: mode field in special modes decides power-down
  logic [15:0] bctrlSoft;
  always_comb begin
    bctrlSoft                     = bctrl_reg;
    bctrlSoft[`PSCL_BC_SOFTRST]   = 1'b0;
    bctrlSoft[`PSCL_BC_PDOWN]     = (mode_reg == 3'h6);
  end

  always_comb begin
    state_next  = state_reg;
    bctrl_next  = bctrl_reg;
    advert_next = advert_reg;
    addr_next   = addr_reg;
    mode_next   = mode_reg;
    ifKind_next = ifKind_reg;
    swCnt_next  = swCnt_reg;
    case (state_reg)
      PSCL_HWRST: begin
        // registers load two cycles after the last strap capture of a pin reset, one after a system reset
        bctrl_next  = bctrlFromStrap;
        advert_next = advertFromStrap;
        addr_next   = {2'b00, straps_reg.mgmtAddressStrap};
        mode_next   = straps_reg.modeStrap;
        ifKind_next = straps_reg.reducedIfSelectStrap;
        state_next  = PSCL_RUN;
      end
      PSCL_SWRST: begin
        // configuration bits kept except power-down, taken from the mode field; no strap reload
        bctrl_next = bctrlSoft;
        swCnt_next = swCnt_reg - 8'h01;
        if (swDone) begin
          state_next = PSCL_RUN;
        end
      end
      PSCL_RUN: begin
        if (swResetReq) begin
          state_next = PSCL_SWRST;
          swCnt_next = `PSCL_SOFTRST_CYCLES;
          bctrl_next = regWriteData;
        end else if (regWrite) begin
          // host reconfiguration
          case (regAddr)
            `PSCL_ADDR_BCTRL:   bctrl_next  = regWriteData;
            `PSCL_ADDR_ADVERT:  advert_next = regWriteData;
            `PSCL_ADDR_SPMODES: begin
              addr_next = regWriteData[`PSCL_SM_ADDR_LO +: 5];
              mode_next = regWriteData[`PSCL_SM_MODE_LO +: 3];
            end
            default: ;
          endcase
        end
      end
      default: state_next = PSCL_RUN;
    endcase
    if (hwReload) begin
      state_next = PSCL_HWRST;
    end
  end

  // core configuration follows register contents
  always_comb begin
    coreCfg_next.speed100          = bctrl_reg[`PSCL_BC_SPEED];
    coreCfg_next.autoNegEnable     = bctrl_reg[`PSCL_BC_ANEN];
    coreCfg_next.fullDuplex        = bctrl_reg[`PSCL_BC_DUPLEX];
    coreCfg_next.powerDown         = bctrl_reg[`PSCL_BC_PDOWN];
    coreCfg_next.crsOnTransmit     = ~bctrl_reg[`PSCL_BC_DUPLEX]
                                     & (mode_reg != 3'h5);
    coreCfg_next.repeaterMode      = (mode_reg == 3'h5);
    coreCfg_next.macIfKindBit      = ifKind_reg;
    coreCfg_next.irqPinIsInterrupt = straps_reg.irqPinFunctionStrap;
  end

  // register reads
  always_comb begin
    case (regAddr)
      `PSCL_ADDR_BCTRL:   readMux = bctrl_reg;
      `PSCL_ADDR_ADVERT:  readMux = advert_reg;
      `PSCL_ADDR_SPMODES: readMux = {1'b0, ifKind_reg, 6'h00, mode_reg, addr_reg};
      `PSCL_ADDR_STRAPS:  readMux = {8'h00, straps_reg};
      default:            readMux = 16'h0000;
    endcase
  end

  // straps follow pins throughout hardware reset, frozen after
  always_ff @(posedge clk) begin
    if (inHwReset) begin
      straps_reg <= pinStraps;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      pinLowSeen_reg <= 1'b0;
    end else begin
      pinLowSeen_reg <= ~pinResetLow;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg   <= PSCL_HWRST;
      bctrl_reg   <= `PSCL_BCTRL_RST;
      advert_reg  <= `PSCL_ADVERT_RST;
      addr_reg    <= `PSCL_ADDR_DEFAULT;
      mode_reg    <= 3'h0;
      ifKind_reg  <= 1'b0;
      swCnt_reg   <= 8'h00;
      coreCfg_reg <= '0;
    end else begin
      state_reg   <= state_next;
      bctrl_reg   <= bctrl_next;
      advert_reg  <= advert_next;
      addr_reg    <= addr_next;
      mode_reg    <= mode_next;
      ifKind_reg  <= ifKind_next;
      swCnt_reg   <= swCnt_next;
      coreCfg_reg <= coreCfg_next;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      regReadData    <= 16'h0000;
      frameMatch_reg <= 1'b0;
      seed_reg       <= 5'h00;
    end else begin
      regReadData    <= regRead ? readMux : 16'h0000;
      frameMatch_reg <= (frameAddress == addr_reg);
      seed_reg       <= addr_reg;
    end
  end

  assign frameMatch    = frameMatch_reg;
  assign scramblerSeed = seed_reg;
  assign coreCfg       = coreCfg_reg;
endmodule : pscl_loader
`default_nettype wire

//--- hdl/pscl_params.svh
`ifndef PSCL_PARAMS_SVH
`define PSCL_PARAMS_SVH

// register indices on the plain port
`define PSCL_ADDR_BCTRL      5'h00
`define PSCL_ADDR_ADVERT     5'h04
`define PSCL_ADDR_SPMODES    5'h12
`define PSCL_ADDR_STRAPS     5'h1C

// basic-control fields
`define PSCL_BC_SOFTRST      15
`define PSCL_BC_SPEED        13
`define PSCL_BC_ANEN         12
`define PSCL_BC_PDOWN        11
`define PSCL_BC_DUPLEX       8

// special-modes fields
`define PSCL_SM_IFKIND       14
`define PSCL_SM_MODE_LO      5
`define PSCL_SM_ADDR_LO      0

// reset values
`define PSCL_BCTRL_RST       16'h3000
`define PSCL_ADVERT_RST      16'h01E1
`define PSCL_ADVERT_MASK     16'h01E0
`define PSCL_ADDR_DEFAULT    5'h00

// soft reset counts down from this many cycles; the bit self-clears on its first cycle
`define PSCL_SOFTRST_CYCLES  8'h10

`endif

//--- hdl/pscl_pkg.sv
`default_nettype none
package pscl_pkg;
  typedef struct packed {
    logic [2:0] mgmtAddressStrap;
    logic [2:0] modeStrap;
    logic       reducedIfSelectStrap;
    logic       irqPinFunctionStrap;
  } pscl_straps_type;

  typedef struct packed {
    logic       speed100;
    logic       autoNegEnable;
    logic       fullDuplex;
    logic       powerDown;
    logic       crsOnTransmit;
    logic       repeaterMode;
    logic       macIfKindBit;
    logic       irqPinIsInterrupt;
  } pscl_core_cfg_type;

  typedef enum logic [2:0] {
    PSCL_RUN   = 3'b001,
    PSCL_HWRST = 3'b010,
    PSCL_SWRST = 3'b100
  } pscl_state_type;
endpackage : pscl_pkg
`default_nettype wire
